// >>> hw/rtc_alarm_unit.sv
// real-time clock alarm unit with time and date value registers on AHB-Lite
// assumes hresetn is the power-on reset and rtc_tick is one hclk pulse per RTC clock
//
// Functional notes
// - alarm events only while alarm enabled
// - chime wraps counter 00 to FF, else stops
// - pulse initial value writable while alarm disabled
// - enabled: writes ignored, reads show pulse level
// - read-unsafe flag within 32 RTC clocks
// - interval codes half-second through year
// - yearly February 29 fires every four years
// - last event without chime clears enable
// - counter value plus one alarm events
// - counter decrements on every alarm event while above 00
// - alarm control cleared by power-on only
// - hours BCD in bits 31-24
// - minutes BCD in bits 23-16
// - seconds BCD in bits 15-8
// - time bits 7-0 read zero
// - value writes need write unlock bit
// - date year, month, day BCD fields
// - weekday bits 3-0, bits 7-4 zero
// - seconds write clears half-second phase
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`include "rtc_regs.svh"
`default_nettype none
module rtc_alarm_unit #(
   parameter int unsigned HALF_TICKS = `RTC_CLK_HZ * `RTC_HALF_SEC_MS / 1000
) (
   input  wire logic           hclk,
   input  wire logic           hresetn,
   input  wire logic           hsel,
   input  wire logic [7:0]     haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire rtc_pkg::word_t hwdata,
   input  wire logic           hready,
   output logic                hreadyout,
   output logic                hresp,
   output rtc_pkg::word_t      hrdata,
   input  wire logic           rtc_tick,
   output logic                alarm_pulse,
   output logic                alarm_event
);
   import rtc_pkg::*;

   localparam int unsigned   PW         = $clog2(HALF_TICKS);
   localparam logic [PW-1:0] PRESC_LAST = PW'(HALF_TICKS - 1);
   localparam logic [PW-1:0] PRESC_NEAR = PW'(HALF_TICKS - `RTC_SYNC_WINDOW);

   rtc_cal_if cal_bus ();

   rtc_calendar u_cal (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cal     (cal_bus)
   );

   // bus slave: writes take no wait state, reads take one
   bus_state_t      st_r;
   bus_state_t      st_nxt;
   logic [7:0]      addr_r;
   logic [7:0]      addr_nxt;
   logic            wr_r;
   logic            wr_nxt;
   word_t           rdata_r;
   word_t           rdata_nxt;
   word_t           rd_mux;
   logic            take;
   logic            wr_ac;
   logic            wr_cc;
   logic            wr_at;
   logic            wr_ad;
   logic            wr_tm;
   logic            wr_dt;

   // clock control, prescaler and alarm state
   logic            on_r;
   logic            on_nxt;
   logic            unlock_r;
   logic            unlock_nxt;
   logic [PW-1:0]   presc_r;
   logic [PW-1:0]   presc_nxt;
   logic            half_r;
   logic            half_nxt;
   logic            unsafe_r;
   logic            unsafe_nxt;
   logic            check_r;
   logic            check_nxt;
   logic            half_roll;
   logic            en_r;
   logic            en_nxt;
   logic            chime_r;
   logic            chime_nxt;
   logic            pulse_r;
   logic            pulse_nxt;
   alarm_interval_t mask_r;
   alarm_interval_t mask_nxt;
   logic [7:0]      rpt_r;
   logic [7:0]      rpt_nxt;
   word_t           atime_r;
   word_t           atime_nxt;
   word_t           adate_r;
   word_t           adate_nxt;
   logic            evt;
   logic            evt_r;
   logic            match;

   assign take  = hsel & hready & htrans[1];
   assign wr_ac = wr_r & (addr_r == `RTC_OFS_ALARM_CTL);
   assign wr_cc = wr_r & (addr_r == `RTC_OFS_CLK_CTL);
   assign wr_at = wr_r & (addr_r == `RTC_OFS_ALARM_TIME);
   assign wr_ad = wr_r & (addr_r == `RTC_OFS_ALARM_DATE);
   assign wr_tm = wr_r & (addr_r == `RTC_OFS_TIME) & unlock_r;
   assign wr_dt = wr_r & (addr_r == `RTC_OFS_DATE) & unlock_r;

   always_comb begin
      st_nxt    = st_r;
      addr_nxt  = addr_r;
      wr_nxt    = 1'b0;
      rdata_nxt = rdata_r;
      case (st_r)
         BUS_IDLE:  st_nxt = BUS_IDLE;
         BUS_RWAIT: begin
            rdata_nxt = rd_mux;
            st_nxt    = BUS_RDATA;
         end
         BUS_RDATA: st_nxt = BUS_IDLE;
         default:   st_nxt = BUS_IDLE;
      endcase
      if (take) begin
         addr_nxt = haddr;
         wr_nxt   = hwrite & (hsize == 3'b010);
         if (!hwrite)
            st_nxt = BUS_RWAIT;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r    <= BUS_IDLE;
         addr_r  <= 8'h00;
         wr_r    <= 1'b0;
         rdata_r <= `RTC_WORD_RST;
      end else begin
         st_r    <= st_nxt;
         addr_r  <= addr_nxt;
         wr_r    <= wr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   always_comb begin
      case (addr_r)
         `RTC_OFS_ALARM_CTL:  rd_mux = {16'h0000, en_r, chime_r, pulse_r, unsafe_r, mask_r, rpt_r};
         `RTC_OFS_TIME:       rd_mux = cal_bus.time_value;
         `RTC_OFS_DATE:       rd_mux = cal_bus.date_value;
         `RTC_OFS_ALARM_TIME: rd_mux = atime_r;
         `RTC_OFS_ALARM_DATE: rd_mux = adate_r;
         `RTC_OFS_CLK_CTL:    rd_mux = {16'h0000, on_r, 11'h000, unlock_r, unsafe_r, half_r, 1'b0};
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   assign hreadyout = (st_r != BUS_RWAIT);
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;

   assign cal_bus.wr_time  = wr_tm;
   assign cal_bus.wr_date  = wr_dt;
   assign cal_bus.wdata    = hwdata;
   assign half_roll        = on_r & rtc_tick & (presc_r == PRESC_LAST);
   assign cal_bus.sec_tick = half_roll & half_r;

   // half-second prescaler; a time write restarts the second at its first half
   always_comb begin
      on_nxt     = on_r;
      unlock_nxt = unlock_r;
      presc_nxt  = presc_r;
      half_nxt   = half_r;
      if (half_roll) begin
         presc_nxt = '0;
         half_nxt  = ~half_r;
      end else if (on_r & rtc_tick) begin
         presc_nxt = presc_r + 1'b1;
      end
      if (wr_tm) begin
         presc_nxt = '0;
         half_nxt  = 1'b0;
      end
      if (wr_cc) begin
         on_nxt     = hwdata[`RTC_CC_ON];
         unlock_nxt = hwdata[`RTC_CC_UNLOCK];
      end
      unsafe_nxt = on_r & (presc_r >= PRESC_NEAR);
      check_nxt  = half_roll & ((mask_r == IV_HALF_SEC) | half_r);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_r     <= 1'b0;
         unlock_r <= 1'b0;
         presc_r  <= '0;
         half_r   <= 1'b0;
         unsafe_r <= 1'b0;
         check_r  <= 1'b0;
      end else begin
         on_r     <= on_nxt;
         unlock_r <= unlock_nxt;
         presc_r  <= presc_nxt;
         half_r   <= half_nxt;
         unsafe_r <= unsafe_nxt;
         check_r  <= check_nxt;
      end
   end

   // compare runs one cycle after the tick, against the already advanced time
   always_comb begin
      case (mask_r)
         IV_HALF_SEC, IV_SEC: match = 1'b1;
         IV_10SEC: match = cal_bus.time_value[11:8] == atime_r[11:8];
         IV_MIN:   match = cal_bus.time_value[15:8] == atime_r[15:8];
         IV_10MIN: match = cal_bus.time_value[19:8] == atime_r[19:8];
         IV_HOUR:  match = cal_bus.time_value[23:8] == atime_r[23:8];
         IV_DAY:   match = cal_bus.time_value[31:8] == atime_r[31:8];
         IV_WEEK:  match = cal_bus.time_value[31:8] == atime_r[31:8] && cal_bus.date_value[3:0] == adate_r[3:0];
         IV_MONTH: match = cal_bus.time_value[31:8] == atime_r[31:8] && cal_bus.date_value[15:8] == adate_r[15:8];
         // a 29 February match can only occur in leap years
         IV_YEAR:  match = cal_bus.time_value[31:8] == atime_r[31:8] && cal_bus.date_value[23:8] == adate_r[23:8];
         default:  match = 1'b0;
      endcase
   end

   assign evt = en_r & check_r & match;

   always_comb begin
      en_nxt    = en_r;
      chime_nxt = chime_r;
      pulse_nxt = pulse_r;
      mask_nxt  = mask_r;
      rpt_nxt   = rpt_r;
      atime_nxt = atime_r;
      adate_nxt = adate_r;
      if (evt) begin
         pulse_nxt = ~pulse_r;
         if (rpt_r != 8'h00)
            rpt_nxt = rpt_r - 8'h01;
         else if (chime_r)
            rpt_nxt = `RTC_RPT_WRAP;
         else
            en_nxt = 1'b0;
      end
      if (wr_ac) begin
         en_nxt    = hwdata[`RTC_AC_EN];
         chime_nxt = hwdata[`RTC_AC_CHIME];
         mask_nxt  = alarm_interval_t'(hwdata[11:8]);
         rpt_nxt   = hwdata[7:0];
         if (!en_r)
            pulse_nxt = hwdata[`RTC_AC_PIV];
      end
      if (wr_at)
         atime_nxt = hwdata & `RTC_TIME_MASK;
      if (wr_ad)
         adate_nxt = hwdata & `RTC_ADATE_MASK;
   end

   // only the power-on reset clears the alarm state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_r    <= 1'b0;
         chime_r <= 1'b0;
         pulse_r <= 1'b0;
         mask_r  <= IV_HALF_SEC;
         rpt_r   <= 8'h00;
         atime_r <= `RTC_WORD_RST;
         adate_r <= `RTC_WORD_RST;
         evt_r   <= 1'b0;
      end else begin
         en_r    <= en_nxt;
         chime_r <= chime_nxt;
         pulse_r <= pulse_nxt;
         mask_r  <= mask_nxt;
         rpt_r   <= rpt_nxt;
         atime_r <= atime_nxt;
         adate_r <= adate_nxt;
         evt_r   <= evt;
      end
   end

   assign alarm_pulse = pulse_r;
   assign alarm_event = evt_r;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_read_taken;
      take && !hwrite;
   endsequence
   sequence s_read_answer;
      !hreadyout ##1 hreadyout;
   endsequence

   property p_read_wait;
      s_read_taken |=> s_read_answer;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read not answered after one wait state");

   property p_no_evt_off;
      !en_r |-> !evt ##1 !alarm_event;
   endproperty
   a_no_evt_off: assert property (p_no_evt_off) else $error("alarm event while disabled");

   property p_wrap;
      evt && rpt_r == 8'h00 && chime_r && !wr_ac |=> rpt_r == 8'hFF && en_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("chime counter did not wrap");

   property p_piv_write;
      wr_ac && !en_r |=> pulse_r == $past(hwdata[13]);
   endproperty
   a_piv_write: assert property (p_piv_write) else $error("pulse start level not written");

   property p_piv_locked;
      wr_ac && en_r && !evt |=> pulse_r == $past(pulse_r);
   endproperty
   a_piv_locked: assert property (p_piv_locked) else $error("pulse level changed by write");

   property p_unsafe;
      on_r && presc_r >= PRESC_NEAR |=> unsafe_r;
   endproperty
   a_unsafe: assert property (p_unsafe) else $error("read-unsafe flag missing");

   property p_autoclear;
      evt && rpt_r == 8'h00 && !chime_r && !wr_ac |=> !en_r && rpt_r == 8'h00;
   endproperty
   a_autoclear: assert property (p_autoclear) else $error("enable not cleared on last event");

   property p_decrement;
      evt && rpt_r != 8'h00 && !wr_ac |=> rpt_r == $past(rpt_r) - 8'h01 && en_r;
   endproperty
   a_decrement: assert property (p_decrement) else $error("repeat counter not decremented");

   property p_time_low_zero;
      st_r == BUS_RDATA && addr_r == `RTC_OFS_TIME |-> hrdata[7:0] == 8'h00;
   endproperty
   a_time_low_zero: assert property (p_time_low_zero) else $error("time low byte not zero");

   property p_locked_time;
      wr_r && addr_r == `RTC_OFS_TIME && !unlock_r && !cal_bus.sec_tick |=>
         cal_bus.time_value == $past(cal_bus.time_value);
   endproperty
   a_locked_time: assert property (p_locked_time) else $error("locked time register changed");

   property p_half_clear;
      wr_tm |=> !half_r && presc_r == '0;
   endproperty
   a_half_clear: assert property (p_half_clear) else $error("half-second phase not cleared");
endmodule
`default_nettype wire

// >>> hw/rtc_regs.svh
// register map, field positions, reset values and timing counts of the alarm unit
// assumes the includer compiles it once per file; definitions only
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

`define RTC_OFS_ALARM_CTL  8'h00
`define RTC_OFS_TIME       8'h04
`define RTC_OFS_DATE       8'h08
`define RTC_OFS_ALARM_TIME 8'h0C
`define RTC_OFS_ALARM_DATE 8'h10
`define RTC_OFS_CLK_CTL    8'h14

`define RTC_AC_EN          15
`define RTC_AC_CHIME       14
`define RTC_AC_PIV         13
`define RTC_CC_ON          15
`define RTC_CC_UNLOCK      3

`define RTC_TIME_MASK      32'hFFFF_FF00
`define RTC_DATE_MASK      32'hFFFF_FF0F
`define RTC_ADATE_MASK     32'h00FF_FF0F
`define RTC_TIME_RST       32'h0000_0000
`define RTC_DATE_RST       32'h0001_0100
`define RTC_WORD_RST       32'h0000_0000
`define RTC_RPT_WRAP       8'hFF

`define RTC_CLK_HZ         32768
`define RTC_HALF_SEC_MS    500
`define RTC_SYNC_WINDOW    32

`endif

// >>> hw/rtc_pkg.sv
// types shared by the alarm unit and its calendar
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rtc_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_RWAIT = 2'b01, BUS_RDATA = 2'b11} bus_state_t;
   typedef enum logic [3:0] {
      IV_HALF_SEC = 4'h0, IV_SEC = 4'h1, IV_10SEC = 4'h2, IV_MIN = 4'h3, IV_10MIN = 4'h4,
      IV_HOUR = 4'h5, IV_DAY = 4'h6, IV_WEEK = 4'h7, IV_MONTH = 4'h8, IV_YEAR = 4'h9
   } alarm_interval_t;
endpackage
`default_nettype wire

// >>> hw/rtc_cal_if.sv
// link between the alarm unit and the calendar counters
// assumes both ends run on hclk
`default_nettype none
interface rtc_cal_if;
   import rtc_pkg::*;
   logic  sec_tick;
   logic  wr_time;
   logic  wr_date;
   word_t wdata;
   word_t time_value;
   word_t date_value;
   modport ctl (output sec_tick, wr_time, wr_date, wdata, input time_value, date_value);
   modport cal (input sec_tick, wr_time, wr_date, wdata, output time_value, date_value);
endinterface
`default_nettype wire

// >>> hw/rtc_calendar.sv
// BCD time of day and date counters with month lengths and leap years
// assumes sec_tick is a one-cycle pulse once per second and writes are already unlocked
`include "rtc_regs.svh"
`default_nettype none
module rtc_calendar (
   input wire logic hclk,
   input wire logic hresetn,
   rtc_cal_if.cal   cal
);
   import rtc_pkg::*;

   word_t      time_r;
   word_t      time_nxt;
   word_t      date_r;
   word_t      date_nxt;
   logic [8:0] s_b;
   logic [8:0] m_b;
   logic [8:0] h_b;
   logic [8:0] d_b;
   logic [8:0] mo_b;
   logic [8:0] y_b;

   // carry in bit 8, next BCD pair below; out-of-range values also wrap
   function automatic logic [8:0] bump(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
      if (v >= last)
         bump = {1'b1, first};
      else if (v[3:0] >= 4'h9)
         bump = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         bump = {1'b0, v[7:4], v[3:0] + 4'h1};
   endfunction

   // years 00..99 map to 2000..2099, so every year divisible by four is leap
   function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02:                      month_last = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
         default:                    month_last = 8'h31;
      endcase
   endfunction

   always_comb begin
      time_nxt = time_r;
      date_nxt = date_r;
      s_b      = bump(time_r[15:8], 8'h59, 8'h00);
      m_b      = bump(time_r[23:16], 8'h59, 8'h00);
      h_b      = bump(time_r[31:24], 8'h23, 8'h00);
      d_b      = bump(date_r[15:8], month_last(date_r[23:16], date_r[31:24]), 8'h01);
      mo_b     = bump(date_r[23:16], 8'h12, 8'h01);
      y_b      = bump(date_r[31:24], 8'h99, 8'h00);
      if (cal.sec_tick) begin
         time_nxt[15:8] = s_b[7:0];
         if (s_b[8]) begin
            time_nxt[23:16] = m_b[7:0];
            if (m_b[8]) begin
               time_nxt[31:24] = h_b[7:0];
               if (h_b[8]) begin
                  date_nxt[3:0]  = (date_r[3:0] >= 4'h6) ? 4'h0 : date_r[3:0] + 4'h1;
                  date_nxt[15:8] = d_b[7:0];
                  if (d_b[8]) begin
                     date_nxt[23:16] = mo_b[7:0];
                     if (mo_b[8])
                        date_nxt[31:24] = y_b[7:0];
                  end
               end
            end
         end
      end
      // a software write wins over a tick in the same cycle
      if (cal.wr_time)
         time_nxt = cal.wdata & `RTC_TIME_MASK;
      if (cal.wr_date)
         date_nxt = cal.wdata & `RTC_DATE_MASK;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         time_r <= `RTC_TIME_RST;
         date_r <= `RTC_DATE_RST;
      end else begin
         time_r <= time_nxt;
         date_r <= date_nxt;
      end
   end

   assign cal.time_value = time_r;
   assign cal.date_value = date_r;
endmodule
`default_nettype wire

// >>> tb/rtc_alarm_unit_test.sv
// self-checking bench for the alarm unit and its time and date registers over AHB-Lite
// assumes hw/ is on the include path and rtc_pkg is compiled first
`include "rtc_regs.svh"
`default_nettype none
module rtc_alarm_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_pkg::*;

   localparam int    HT = 64;
   localparam word_t T0 = 32'h1234_5600;
   localparam word_t D0 = 32'h2403_0305;

   logic        hclk      = 1'b0;
   logic        hresetn   = 1'b0;
   logic        hsel      = 1'b0;
   logic [7:0]  haddr     = 8'h00;
   logic [1:0]  htrans    = 2'b00;
   logic        hwrite    = 1'b0;
   logic [2:0]  hsize     = 3'b010;
   word_t       hwdata    = 32'h0000_0000;
   logic        hreadyout;
   logic        hresp;
   word_t       hrdata;
   logic        rtc_tick  = 1'b0;
   logic        alarm_pulse;
   logic        alarm_event;
   int          fail_count = 0;
   int          n_checks   = 0;
   int          n_events   = 0;
   word_t       rd;

   rtc_alarm_unit #(.HALF_TICKS(HT)) rtc_alarm_unit_i (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hsize       (hsize),
      .hwdata      (hwdata),
      .hready      (hreadyout),
      .hreadyout   (hreadyout),
      .hresp       (hresp),
      .hrdata      (hrdata),
      .rtc_tick    (rtc_tick),
      .alarm_pulse (alarm_pulse),
      .alarm_event (alarm_event)
   );

   always #4 hclk = ~hclk;

   // one rtc clock every two bus clocks
   always @(posedge hclk) begin
      rtc_tick <= ~rtc_tick;
      if (alarm_event === 1'b1) n_events++;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check_word(input word_t got, input word_t exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         fail_count++;
         $display("ERROR at %0t: bus wait ran out, got %h expected %h", $time, hreadyout, 1'b1);
         give_verdict();
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input word_t d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= 1'b1;
      hsize  <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
   endtask

   task automatic bus_read(input logic [7:0] a, output word_t d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= 1'b0;
      wait_ready();
      htrans <= 2'b00;
      wait_ready();
      d = hrdata;
   endtask

   task automatic read_check(input logic [7:0] a, input word_t mask, input word_t exp);
      bus_read(a, rd);
      check_word(rd & mask, exp);
   endtask

   task automatic do_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
   endtask

   // unit stopped, time, date and alarm set up, then unit started from a fresh second
   task automatic arm(input word_t ctl, input word_t atime);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      bus_write(`RTC_OFS_TIME, T0);
      bus_write(`RTC_OFS_DATE, D0);
      bus_write(`RTC_OFS_ALARM_TIME, atime);
      bus_write(`RTC_OFS_ALARM_DATE, D0 & `RTC_ADATE_MASK);
      bus_write(`RTC_OFS_ALARM_CTL, ctl);
      n_events = 0;
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_8008);
   endtask

   task automatic roll(input word_t t, input word_t d, input word_t et, input word_t ed);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      bus_write(`RTC_OFS_TIME, t);
      bus_write(`RTC_OFS_DATE, d);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_8008);
      repeat (300) @(posedge hclk);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      read_check(`RTC_OFS_TIME, 32'hFFFF_FFFF, et);
      read_check(`RTC_OFS_DATE, 32'hFFFF_FF00, ed);
   endtask

   initial begin
      do_reset();
      read_check(`RTC_OFS_ALARM_CTL, 32'hFFFF_FFFF, `RTC_WORD_RST);
      read_check(`RTC_OFS_TIME, 32'hFFFF_FFFF, `RTC_TIME_RST);
      read_check(`RTC_OFS_DATE, 32'hFFFF_FFFF, `RTC_DATE_RST);
      read_check(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
      check_word({31'h0, hresp}, 32'h0);
      bus_write(`RTC_OFS_TIME, 32'h1111_1111);
      read_check(`RTC_OFS_TIME, 32'hFFFF_FFFF, `RTC_TIME_RST);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      bus_write(`RTC_OFS_TIME, 32'h2359_58FF);
      read_check(`RTC_OFS_TIME, 32'hFFFF_FFFF, 32'h2359_5800);
      bus_write(`RTC_OFS_DATE, 32'h9912_31F6);
      read_check(`RTC_OFS_DATE, 32'hFFFF_FFFF, 32'h9912_3106);
      roll(32'h2359_5900, 32'h9912_3106, 32'h0000_0000, 32'h0001_0100);
      roll(32'h2359_5900, 32'h2402_2804, 32'h0000_0000, 32'h2402_2900);
      // read-unsafe flag and half-second phase while the unit runs
      bus_write(`RTC_OFS_TIME, T0);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_8008);
      read_check(`RTC_OFS_ALARM_CTL, 32'h0000_1000, 32'h0000_0000);
      repeat (100) @(posedge hclk);
      read_check(`RTC_OFS_ALARM_CTL, 32'h0000_1000, 32'h0000_1000);
      // flag still up: a second read must agree with the first
      read_check(`RTC_OFS_ALARM_CTL, 32'hFFFF_FFFF, 32'h0000_1000);
      repeat (50) @(posedge hclk);
      read_check(`RTC_OFS_CLK_CTL, 32'h0000_0002, 32'h0000_0002);
      bus_write(`RTC_OFS_TIME, T0);
      read_check(`RTC_OFS_CLK_CTL, 32'h0000_0002, 32'h0000_0000);
      // every interval code, once with all fields matching and once with the hours off
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 10; c++) begin
            arm(32'h0000_8000 | (word_t'(c) << 8), (m == 0) ? 32'h1234_5700 : 32'h1334_5700);
            repeat (300) @(posedge hclk);
            check_word(word_t'(n_events), (m == 0 || c <= 5) ? 32'h1 : 32'h0);
         end
      end
      // yearly alarm on 29 February: fires in a leap year, not in the next one
      for (int y = 0; y < 2; y++) begin
         arm(32'h0000_8900, 32'h0000_0000);
         bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
         bus_write(`RTC_OFS_TIME, 32'h2359_5900);
         bus_write(`RTC_OFS_DATE, (y == 0) ? 32'h2402_2804 : 32'h2502_2805);
         bus_write(`RTC_OFS_ALARM_DATE, 32'h0002_2900);
         n_events = 0;
         bus_write(`RTC_OFS_CLK_CTL, 32'h0000_8008);
         repeat (300) @(posedge hclk);
         check_word(word_t'(n_events), (y == 0) ? 32'h1 : 32'h0);
      end
      // pulse level, repeat count of two, enable cleared after the last event
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      bus_write(`RTC_OFS_ALARM_CTL, 32'h0000_0000);
      bus_write(`RTC_OFS_ALARM_CTL, 32'h0000_2000);
      @(posedge hclk);
      check_word({31'h0, alarm_pulse}, 32'h1);
      arm(32'h0000_A002, T0);
      repeat (700) @(posedge hclk);
      check_word(word_t'(n_events), 32'h3);
      check_word({31'h0, alarm_pulse}, 32'h0);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      read_check(`RTC_OFS_ALARM_CTL, 32'hFFFF_CFFF, 32'h0000_0000);
      // chime lets the count wrap and keeps the alarm enabled
      arm(32'h0000_C000, T0);
      repeat (180) @(posedge hclk);
      bus_write(`RTC_OFS_CLK_CTL, 32'h0000_0008);
      check_word(word_t'(n_events), 32'h1);
      read_check(`RTC_OFS_ALARM_CTL, 32'hFFFF_CFFF, 32'h0000_C0FF);
      // pulse is high after one event from a low start; a low pulse bit must not land
      bus_write(`RTC_OFS_ALARM_CTL, 32'h0000_C0FF);
      read_check(`RTC_OFS_ALARM_CTL, 32'h0000_2000, 32'h0000_2000);
      check_word({31'h0, alarm_pulse}, 32'h1);
      do_reset();
      read_check(`RTC_OFS_ALARM_CTL, 32'hFFFF_FFFF, `RTC_WORD_RST);
      give_verdict();
   end
endmodule
`default_nettype wire
